// ===== hw/flash_status_pkg.sv
// constants for the flash status register and parameter table block
// assumes a single serial-side link clock domain and a 100 MHz core clock
package flash_status_pkg;
  // status_one field positions
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned PERR_BIT = 6;
  localparam int unsigned EERR_BIT = 5;
  localparam int unsigned BP_HI_BIT = 4;
  localparam int unsigned BP_LO_BIT = 2;
  localparam int unsigned WEL_BIT = 1;
  localparam int unsigned BUSY_BIT = 0;
  // configuration_one bit that makes block protection volatile
  localparam int unsigned CFG_BP_VOLATILE_BIT = 3;
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [2:0] BP_VOLATILE_RESET = 3'h7;
  // command codes
  localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] CMD_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_CLEAR_WE = 8'h04;
  localparam logic [7:0] CMD_SET_WE = 8'h06;
  localparam logic [7:0] CMD_ERASE_SMALL = 8'h20;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'hD8;
  localparam logic [7:0] CMD_READ_PARAM = 8'h5A;
  // parameter table bytes
  localparam logic [7:0] PT_ALL_MODES = 8'hE6;
  localparam logic [7:0] PT_UNUSED = 8'hFF;
  localparam logic [7:0] PT_SIZE1_HYBRID = 8'h0C;
  localparam logic [7:0] PT_SIZE1_UNIFORM = 8'h12;
  localparam logic [7:0] PT_INST1_HYBRID = 8'h20;
  localparam logic [7:0] PT_INST1_UNIFORM = 8'hD8;
  localparam logic [7:0] PT_SIZE2_HYBRID = 8'h10;
  localparam logic [7:0] PT_SIZE2_UNIFORM = 8'h00;
  localparam logic [7:0] PT_INST2 = 8'hD8;
  localparam logic [7:0] PT_NO_SIZE = 8'h00;
  localparam logic [7:0] PT_WRITE_EN_INST = 8'h06;
  // busy durations in ns, rounded up to core cycles
  localparam int unsigned REG_WRITE_NS = 200;
  localparam int unsigned PROG_NS = 400;
  localparam int unsigned ERASE_NS = 800;
  localparam int unsigned CLK_NS = 10;
  localparam logic [7:0] REG_WRITE_CYC = 8'((REG_WRITE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PROG_CYC = 8'((PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ERASE_CYC = 8'((ERASE_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_REGW = 2'b01,
    OP_PROG = 2'b10,
    OP_ERASE = 2'b11
  } op_t;
endpackage : flash_status_pkg

// ===== hw/flash_status.sv
// status register and parameter table of a serial flash
// assumes: link side gives one command byte (plus one data byte for register writes and
// parameter reads) on link_clk; the array reports errors as core-clock pulses.
`timescale 1ns/1ps
module flash_status
  import flash_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_cmd_valid,
  input wire logic [7:0] link_cmd,
  input wire logic [7:0] link_data,
  output logic [7:0] link_rdata,
  input wire logic write_protect_n,
  input wire logic uniform_sectors,
  input wire logic [7:0] nv_status_init,
  input wire logic program_error,
  input wire logic erase_error,
  output logic [7:0] status_out,
  output logic [7:0] config_out,
  output logic [2:0] protect_range,
  output logic busy
);
  import flash_status_pkg::*;

  // link domain: capture command and toggle an event flag
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic tgl;
    logic [7:0] rdata;
    logic [7:0] st_s1;
    logic [7:0] st_s2;
    logic up_s1;
    logic up_s2;
  } link_state_t;

  // core domain state
  typedef struct packed {
    logic [7:0] ev_cmd;
    logic [7:0] ev_data;
    logic tg_s1;
    logic tg_s2;
    logic tg_seen;
    logic wp_s1;
    logic wp_s2;
    logic un_s1;
    logic un_s2;
    logic lock;
    logic perr;
    logic eerr;
    logic [2:0] bp;
    logic write_enable_latch;
    logic [7:0] cfg;
    op_t op;
    logic [7:0] cnt;
    logic init_done;
    logic up_tgl;
    logic [7:0] status_snap;
    logic uniform_snap;
  } core_state_t;

  link_state_t l_r, l_nxt;
  core_state_t c_r, c_nxt;
  logic [7:0] status_w;
  logic cmd_ev;

  // table lookup, purely from offset and sector arrangement
  function automatic logic [7:0] table_byte(input logic [7:0] off, input logic uni);
    logic [7:0] b;
    b = PT_UNUSED;
    unique case (off)
      8'h02: b = PT_UNUSED;                                    // write enable inst 06h flag set
      8'h12: b = PT_ALL_MODES;
      8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1A, 8'h1B: b = PT_UNUSED;
      8'h18, 8'h19, 8'h1C, 8'h1D: b = PT_UNUSED;
      8'h1E: b = uni ? PT_SIZE1_UNIFORM : PT_SIZE1_HYBRID;
      8'h1F: b = uni ? PT_INST1_UNIFORM : PT_INST1_HYBRID;
      8'h20: b = uni ? PT_SIZE2_UNIFORM : PT_SIZE2_HYBRID;
      8'h21: b = PT_INST2;
      8'h22, 8'h24: b = PT_NO_SIZE;
      8'h23, 8'h25: b = PT_UNUSED;
      8'hFE: b = PT_WRITE_EN_INST;                             // advertised enable opcode
      default: b = PT_UNUSED;
    endcase
    return b;
  endfunction : table_byte

  assign status_w = {c_r.lock, c_r.perr, c_r.eerr, c_r.bp, c_r.write_enable_latch, c_r.op != OP_IDLE};

  // link logic: command capture and read answer from synchronised snapshot
  // the status word is steady only between operations, so a host polls it with busy low;
  // a read racing the end of an operation may mix old and new bits in that one answer
  always_comb begin
    l_nxt = l_r;
    l_nxt.st_s1 = c_r.status_snap;
    l_nxt.st_s2 = l_r.st_s1;
    l_nxt.up_s1 = c_r.uniform_snap;
    l_nxt.up_s2 = l_r.up_s1;
    if (link_cmd_valid) begin
      l_nxt.cmd = link_cmd;
      l_nxt.data = link_data;
      l_nxt.tgl = ~l_r.tgl;
      if (link_cmd == CMD_READ_STATUS) begin
        l_nxt.rdata = l_r.st_s2;                           // read only, nothing else moves
      end else if (link_cmd == CMD_READ_PARAM) begin
        l_nxt.rdata = table_byte(link_data, l_r.up_s2);
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // command event arrives when synchronised toggle differs from last seen
  assign cmd_ev = c_r.tg_s2 != c_r.tg_seen;

  // core logic: flags, latch, protection and busy sequencing
  always_comb begin
    c_nxt = c_r;
    c_nxt.tg_s1 = l_r.tgl;
    c_nxt.tg_s2 = c_r.tg_s1;
    c_nxt.tg_seen = c_r.tg_s2;
    c_nxt.wp_s1 = write_protect_n;
    c_nxt.wp_s2 = c_r.wp_s1;
    c_nxt.un_s1 = uniform_sectors;
    c_nxt.un_s2 = c_r.un_s1;
    c_nxt.ev_cmd = l_r.cmd;
    c_nxt.ev_data = l_r.data;
    c_nxt.uniform_snap = c_r.un_s2;
    c_nxt.status_snap = status_w;
    // capture non-volatile image once after reset release
    if (!c_r.init_done) begin
      c_nxt.init_done = 1'b1;
      c_nxt.lock = nv_status_init[LOCK_BIT];
      c_nxt.bp = c_r.cfg[CFG_BP_VOLATILE_BIT] ? BP_VOLATILE_RESET
                                               : nv_status_init[BP_HI_BIT:BP_LO_BIT];
    end
    // busy countdown ends the operation
    if (c_r.op != OP_IDLE) begin
      if (c_r.cnt == 8'h00) begin
        c_nxt.op = OP_IDLE;
      end else begin
        c_nxt.cnt = c_r.cnt - 8'h01;
      end
    end
    // commands taken only while idle
    if (cmd_ev && c_r.op == OP_IDLE && c_r.init_done) begin
      unique case (c_r.ev_cmd)
        CMD_SET_WE: c_nxt.write_enable_latch = 1'b1;
        CMD_CLEAR_WE: c_nxt.write_enable_latch = 1'b0;
        CMD_WRITE_REGS: begin
          // latch needed and lock with low pin freezes it
          if (c_r.write_enable_latch && !(c_r.lock && !c_r.wp_s2)) begin
            c_nxt.lock = c_r.ev_data[LOCK_BIT];
            c_nxt.bp = c_r.ev_data[BP_HI_BIT:BP_LO_BIT];
            c_nxt.op = OP_REGW;
            c_nxt.cnt = REG_WRITE_CYC;
          end
        end
        CMD_PROGRAM: begin
          if (c_r.write_enable_latch) begin
            c_nxt.op = OP_PROG;
            c_nxt.cnt = PROG_CYC;
            c_nxt.perr = 1'b0;
          end
        end
        CMD_ERASE_SMALL, CMD_ERASE_BLOCK: begin
          if (c_r.write_enable_latch) begin
            c_nxt.op = OP_ERASE;
            c_nxt.cnt = ERASE_CYC;
            c_nxt.eerr = 1'b0;
          end
        end
        default: c_nxt.write_enable_latch = c_r.write_enable_latch;
      endcase
    end
    // errors only while the matching operation runs; set wins
    if (program_error && c_r.op == OP_PROG) begin
      c_nxt.perr = 1'b1;
    end
    if (erase_error && c_r.op == OP_ERASE) begin
      c_nxt.eerr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_r <= '0;
      c_r.cfg <= CONFIG_RESET;
      c_r.status_snap <= STATUS_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  // outputs
  assign status_out = c_r.status_snap;
  assign config_out = c_r.cfg;
  assign protect_range = c_r.bp;
  assign busy = c_r.op != OP_IDLE;
  assign link_rdata = l_r.rdata;

  // write protection and the enable latch
  AST_LOCK_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_ev && c_r.op == OP_IDLE && c_r.init_done && c_r.ev_cmd == CMD_WRITE_REGS && c_r.lock && !c_r.wp_s2)
    |=> $stable(c_r.lock) && $stable(c_r.bp)) else $error("locked write changed status");
  AST_WEL_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_ev && c_r.op == OP_IDLE && !c_r.write_enable_latch) |=> !busy) else $error("op started without latch");
  AST_WEL_ACCEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_ev && c_r.op == OP_IDLE && c_r.init_done && c_r.write_enable_latch && c_r.ev_cmd == CMD_PROGRAM)
    |=> busy [*8]) else $error("program not accepted");
  AST_WEL_ONLY_CMD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(c_r.write_enable_latch) |-> $past(cmd_ev) && ($past(c_r.ev_cmd) == CMD_SET_WE || $past(c_r.ev_cmd) == CMD_CLEAR_WE))
    else $error("latch moved without enable command");
  AST_WEL_KEPT_BY_REGW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_ev && c_r.op == OP_IDLE && c_r.init_done && c_r.ev_cmd == CMD_WRITE_REGS) |=> $stable(c_r.write_enable_latch))
    else $error("register write moved the latch");

  // error flags: set only by the matching operation, never by a read
  AST_PERR_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (program_error && c_r.op == OP_PROG) |=> c_r.perr) else $error("program error not flagged");
  AST_PERR_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(c_r.perr) |-> $past(program_error) && $past(c_r.op) == OP_PROG)
    else $error("program error flag rose without a cause");
  AST_EERR_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (erase_error && c_r.op == OP_ERASE) |=> c_r.eerr) else $error("erase error not flagged");
  AST_EERR_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(c_r.eerr) |-> $past(erase_error) && $past(c_r.op) == OP_ERASE)
    else $error("erase error flag rose without a cause");

  // busy sequencing; each length is the package count plus the final zero cycle
  AST_REGW_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_ev && c_r.op == OP_IDLE && c_r.init_done && c_r.write_enable_latch && c_r.ev_cmd == CMD_WRITE_REGS
     && !(c_r.lock && !c_r.wp_s2))
    |=> busy && c_r.op == OP_REGW) else $error("accepted register write not busy");
  AST_BUSY_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(busy) |-> ##[1:90] !busy) else $error("busy never ended");
  AST_REGW_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(busy) && c_r.op == OP_REGW |-> ##21 !busy) else $error("register write busy length wrong");
  AST_PROG_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(busy) && c_r.op == OP_PROG |-> ##41 !busy) else $error("program busy length wrong");
  AST_ERASE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(busy) && c_r.op == OP_ERASE |-> ##81 !busy) else $error("erase busy length wrong");
  AST_BUSY_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (c_r.op != OP_IDLE) |=> $stable(c_r.write_enable_latch) && $stable(c_r.lock) && $stable(c_r.bp))
    else $error("command taken while busy");

  // table answers as seen on the link side
  AST_TABLE_E6: assert property (@(posedge link_clk) disable iff (!rst_n)
    (link_cmd_valid && link_cmd == CMD_READ_PARAM && link_data == 8'h12) |=> link_rdata == PT_ALL_MODES)
    else $error("table byte 12h wrong");
  AST_TABLE_1E: assert property (@(posedge link_clk) disable iff (!rst_n)
    (link_cmd_valid && link_cmd == CMD_READ_PARAM && link_data == 8'h1E)
    |=> link_rdata == ($past(l_r.up_s2) ? PT_SIZE1_UNIFORM : PT_SIZE1_HYBRID)) else $error("sector size wrong");
  AST_TABLE_1F: assert property (@(posedge link_clk) disable iff (!rst_n)
    (link_cmd_valid && link_cmd == CMD_READ_PARAM && link_data == 8'h1F)
    |=> link_rdata == ($past(l_r.up_s2) ? PT_INST1_UNIFORM : PT_INST1_HYBRID)) else $error("erase opcode wrong");
  AST_TABLE_20: assert property (@(posedge link_clk) disable iff (!rst_n)
    (link_cmd_valid && link_cmd == CMD_READ_PARAM && link_data == 8'h20)
    |=> link_rdata == ($past(l_r.up_s2) ? PT_SIZE2_UNIFORM : PT_SIZE2_HYBRID)) else $error("second size wrong");
  AST_TABLE_SECT3: assert property (@(posedge link_clk) disable iff (!rst_n)
    (link_cmd_valid && link_cmd == CMD_READ_PARAM && (link_data == 8'h23 || link_data == 8'h25))
    |=> link_rdata == PT_UNUSED) else $error("unsupported sector opcode wrong");

  // coverage of the main scenarios
  COV_PROG: cover property (@(posedge ref_clk) disable iff (!rst_n) c_r.op == OP_PROG ##1 c_r.op == OP_IDLE);
  COV_ERASE_ERR: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(c_r.eerr));
  COV_LOCKED: cover property (@(posedge ref_clk) disable iff (!rst_n) c_r.lock && !c_r.wp_s2 && cmd_ev);
  COV_WEL_SET: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(c_r.write_enable_latch));
  COV_TABLE_UNIFORM: cover property (@(posedge link_clk) disable iff (!rst_n)
    link_cmd_valid && link_cmd == CMD_READ_PARAM && l_r.up_s2);
endmodule : flash_status

// ===== tb/flash_host_model.sv
// host-side command source for the flash status block
// assumes the bench gates link_clk with link_run so the clock stands still between commands
`timescale 1ns/1ps
module flash_host_model (
  input wire logic link_clk,
  output logic link_run,
  output logic link_cmd_valid,
  output logic [7:0] link_cmd,
  output logic [7:0] link_data
);
  initial begin
    link_run = 1'b0;
    link_cmd_valid = 1'b0;
    link_cmd = 8'h00;
    link_data = 8'h00;
  end
  // one command with its data byte, then the idle gap before the next
  task automatic send(input logic [7:0] cmd, input logic [7:0] data);
    link_run = 1'b1;
    repeat (3) @(posedge link_clk);
    link_cmd_valid <= 1'b1;
    link_cmd <= cmd;
    link_data <= data;
    @(posedge link_clk);
    link_cmd_valid <= 1'b0;
    // released lines show the inverse so a stale byte never passes as good
    link_cmd <= ~cmd;
    link_data <= ~data;
    repeat (6) @(posedge link_clk);
    link_run = 1'b0;
  endtask : send
endmodule : flash_host_model

// ===== tb/flash_status_and_param_table_tb.sv
// self-checking bench for the flash status register and parameter table
// assumes the host model is the only source of link commands
`timescale 1ns/1ps
module flash_status_and_param_table_tb;
  import flash_status_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b1;
  logic link_run, link_cmd_valid, write_protect_n, uniform_sectors, program_error, erase_error, busy;
  logic pe_arm, ee_arm;
  logic [7:0] link_cmd, link_data, link_rdata, nv_status_init, status_out, config_out, es;
  logic [2:0] protect_range;
  logic [31:0] seed = 32'h8e09_475f;
  int busy_len, run_len, bad_count, comparisons;
  always #5 ref_clk = ~ref_clk;
  always #6 link_clk = link_run & ~link_clk;
  flash_host_model flash_host_model_i (.link_clk(link_clk), .link_run(link_run),
    .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_data(link_data));
  flash_status flash_status_i (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_data(link_data), .link_rdata(link_rdata),
    .write_protect_n(write_protect_n), .uniform_sectors(uniform_sectors), .nv_status_init(nv_status_init),
    .program_error(program_error), .erase_error(erase_error), .status_out(status_out),
    .config_out(config_out), .protect_range(protect_range), .busy(busy));
  // running total of busy cycles, and one array error pulse early in each armed operation
  // the total is never cleared here, so the tasks take differences instead of racing this process
  always @(posedge ref_clk) begin
    busy_len <= busy_len + int'(busy === 1'b1);
    run_len <= (busy === 1'b1) ? run_len + 1 : 0;
    program_error <= pe_arm & busy & (run_len == 3);
    erase_error <= ee_arm & busy & (run_len == 3);
  end
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8
  // expected table byte per offset and sector arrangement
  function automatic logic [7:0] pt_exp(input logic [7:0] off, input logic uni);
    case (off)
      8'h12: return 8'hE6;
      8'h1E: return uni ? 8'h12 : 8'h0C;
      8'h1F: return uni ? 8'hD8 : 8'h20;
      8'h20: return uni ? 8'h00 : 8'h10;
      8'h21: return 8'hD8;
      8'h22, 8'h24: return 8'h00;
      8'hFE: return 8'h06;
      default: return 8'hFF;
    endcase
  endfunction : pt_exp
  // expected status after one command; lock with pin low refuses register writes
  function automatic logic [7:0] model(input logic [7:0] s, input logic [7:0] c, input logic [7:0] d,
    input logic wpn, input logic err);
    logic [7:0] r;
    r = s;
    if (c == 8'h06) r[1] = 1'b1;
    else if (c == 8'h04) r[1] = 1'b0;
    else if (s[1] && c == 8'h01 && !(s[7] && !wpn)) r = {d[7], s[6:5], d[4:2], s[1:0]};
    else if (s[1] && c == 8'h02) r[6] = err;
    else if (s[1] && (c == 8'h20 || c == 8'hD8)) r[5] = err;
    return r;
  endfunction : model
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic op(input logic [7:0] c, input logic [7:0] d, input logic wpn, input logic err);
    int n;
    int cyc;
    int base;
    n = 0;
    cyc = (c == 8'h01) ? REG_WRITE_CYC + 1 : (c == 8'h02) ? PROG_CYC + 1 : ERASE_CYC + 1;
    if (!es[1] || (c == 8'h01 && es[7] && !wpn) || c == 8'h04 || c == 8'h06) cyc = 0;
    @(posedge ref_clk);
    write_protect_n <= wpn;
    pe_arm <= err && c == 8'h02;
    ee_arm <= err && c != 8'h02;
    repeat (4) @(posedge ref_clk);
    base = busy_len;
    flash_host_model_i.send(c, d);
    while (busy !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    chk("busy settled", 8'h00, 8'(busy));
    repeat (4) @(posedge ref_clk);
    es = model(es, c, d, wpn, err);
    chk("busy cycles", 8'(cyc), 8'(busy_len - base));
    chk("status", es, status_out);
    chk("protect", {5'h00, es[4:2]}, {5'h00, protect_range});
    chk("config", 8'h00, config_out);
  endtask : op
  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    #300_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    rst_n <= 1'b0;
    write_protect_n = 1'b1;
    uniform_sectors = 1'b0;
    nv_status_init = rnd8();
    {pe_arm, ee_arm, program_error, erase_error} = 4'h0;
    busy_len = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    es = {nv_status_init[7], 2'b00, nv_status_init[4:2], 2'b00};
    chk("reset status", es, status_out);
    // table offsets 12h to 25h in both arrangements, the advert at FEh and random offsets
    for (int u = 0; u < 2; u++) begin
      uniform_sectors <= u[0];
      for (int i = 0; i < 24; i++) begin
        logic [7:0] off;
        off = (i < 20) ? 8'(8'h12 + i) : (i == 20) ? 8'hFE : rnd8();
        flash_host_model_i.send(8'h5A, off);
        chk("table", pt_exp(off, u[0]), link_rdata);
      end
    end
    chk("status after table", es, status_out);
    op(8'h01, rnd8(), 1'b1, 1'b0);
    op(8'h02, rnd8(), 1'b1, 1'b1);
    op(8'h06, rnd8(), 1'b1, 1'b0);
    op(8'h01, rnd8() & 8'h7F, 1'b1, 1'b0);
    op(8'h02, rnd8(), 1'b1, 1'b1);
    op(8'h20, rnd8(), 1'b1, 1'b1);
    op(8'hD8, rnd8(), 1'b1, 1'b0);
    op(8'h01, rnd8() | 8'h80, 1'b1, 1'b0);
    op(8'h01, rnd8(), 1'b0, 1'b0);
    op(8'h01, rnd8() & 8'h63, 1'b1, 1'b0);
    op(8'h04, rnd8(), 1'b1, 1'b0);
    op(8'hD8, rnd8(), 1'b1, 1'b1);
    flash_host_model_i.send(8'h05, rnd8());
    chk("status read", es, link_rdata);
    print_verdict();
  end
endmodule : flash_status_and_param_table_tb
